// [src/rpg_top.sv]
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module rpg_top
   import rpg_pkg::*;
#(
   parameter int NUM_DI = NUM_DI_DEF
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [DATA_W-1:0] s_axi_wdata,
   input wire logic [DATA_W/8-1:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [NUM_DI-1:0] di_pin,
   input wire logic [PARAM_W-1:0] fb_cmd_word,
   input wire rpg_src_wr_t fb_src_wr,
   input wire rpg_src_wr_t macro_src_wr,
   input wire logic start_req,
   output logic run_permit,
   output logic coast_stop,
   output logic start_grant,
   output logic persist_pulse,
   output logic store_all,
   output logic edits_blocked
);

   // ****************************************************************
   // Elaboration checks
   // ****************************************************************
   if (NUM_DI < int'(SRC_DI_LAST)) begin : g_bad_di
      $error("NUM_DI too small for the source codes");
   end

   // ****************************************************************
   // Pin synchronisation
   // ****************************************************************
   logic [NUM_DI-1:0] di_s;

   rpg_sync #(
      .WIDTH(NUM_DI)
   ) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_in(di_pin),
      .pin_sync(di_s)
   );

   // ****************************************************************
   // Helpers
   // ****************************************************************
   // Permit from source code, synced inputs and command word
   function automatic logic permit_of(
      input logic signed [PARAM_W-1:0] s,
      input logic [NUM_DI-1:0] di,
      input logic [PARAM_W-1:0] fw);
      logic p;
      p = 1'b0;
      if (s == SRC_NONE) begin
         p = 1'b1;
      end else if (s >= SRC_DI_FIRST && s <= SRC_DI_LAST) begin
         p = di[int'(s - SRC_DI_FIRST)];
      end else if (s == SRC_FIELDBUS) begin
         p = !fw[FB_DISABLE_BIT];
      end else if (s <= SRC_INV_FIRST && s >= SRC_INV_LAST) begin
         p = !di[int'(SRC_INV_FIRST - s)];
      end
      return p;
   endfunction

   // Byte-lane merge of the low parameter half
   function automatic logic [PARAM_W-1:0] merge16(
      input logic [PARAM_W-1:0] old_v,
      input logic [PARAM_W-1:0] new_v,
      input logic [1:0] strb);
      logic [PARAM_W-1:0] m;
      m = old_v;
      if (strb[0]) begin
         m[7:0] = new_v[7:0];
      end
      if (strb[1]) begin
         m[15:8] = new_v[15:8];
      end
      return m;
   endfunction

   // ****************************************************************
   // State
   // ****************************************************************
   logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
   logic awready_r, awready_nxt, wready_r, wready_nxt;
   logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
   logic [PARAM_W-1:0] wdata_r, wdata_nxt;
   logic [1:0] wstrb_r, wstrb_nxt;
   logic bvalid_r, bvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt;
   logic arready_r, arready_nxt, rvalid_r, rvalid_nxt;
   logic [DATA_W-1:0] rdata_r, rdata_nxt;
   logic [1:0] rresp_r, rresp_nxt;
   logic signed [PARAM_W-1:0] src_r, src_nxt;
   logic [PARAM_W-1:0] guard_r, guard_nxt, key_r, key_nxt;
   logic dirty_r, dirty_nxt, store_r, store_nxt;
   logic persist_r, persist_nxt;
   logic permit_r, permit_nxt, coast_r, coast_nxt;
   logic grant_r, grant_nxt;
   logic blocked_r, blocked_nxt;
   logic wr_do;
   logic [PARAM_W-1:0] wv;
   rpg_status_t status;

   assign wr_do = aw_hold_r && w_hold_r && !bvalid_r;
   assign status = '{blocked: guard_r == GUARD_EDITS_BLOCKED,
                     unlocked: key_r == UNLOCK_KEY,
                     dirty: dirty_r, coast: coast_r, permit: permit_r};

   // ****************************************************************
   // Write channel and parameter registers
   // ****************************************************************
   // Address and data latch independently, either order
   always_comb begin
      aw_hold_nxt = aw_hold_r;
      w_hold_nxt = w_hold_r;
      awaddr_nxt = awaddr_r;
      wdata_nxt = wdata_r;
      wstrb_nxt = wstrb_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      src_nxt = src_r;
      guard_nxt = guard_r;
      key_nxt = key_r;
      dirty_nxt = dirty_r;
      store_nxt = 1'b0;
      persist_nxt = 1'b0;
      wv = '0;
      if (s_axi_awvalid && awready_r) begin
         aw_hold_nxt = 1'b1;
         awaddr_nxt = s_axi_awaddr & ADDR_WORD_MASK;
      end
      if (s_axi_wvalid && wready_r) begin
         w_hold_nxt = 1'b1;
         wdata_nxt = s_axi_wdata[PARAM_W-1:0];
         wstrb_nxt = s_axi_wstrb[1:0];
      end
      if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
      if (wr_do) begin
         aw_hold_nxt = 1'b0;
         w_hold_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = RESP_OKAY;
         unique case (awaddr_r)
            ADDR_SRC: begin
               wv = merge16(src_r, wdata_r, wstrb_r);
               // Panel change refused while edits_blocked
               if (guard_r == GUARD_EDITS_BLOCKED || !rpg_src_legal(wv)) begin
                  bresp_nxt = RESP_SLVERR;
               end else begin
                  src_nxt = wv;
                  persist_nxt = (guard_r == GUARD_OPEN);
                  if (guard_r == GUARD_UNSAVED) begin
                     dirty_nxt = 1'b1;
                  end
               end
            end
            ADDR_GUARD: begin
               wv = merge16(guard_r, wdata_r, wstrb_r);
               // One change per code entry, then the entry clears
               if (key_r == UNLOCK_KEY && wv <= GUARD_UNSAVED) begin
                  guard_nxt = wv;
                  key_nxt = KEY_CLEAR;
               end else begin
                  bresp_nxt = RESP_SLVERR;
               end
            end
            ADDR_KEY: begin
               key_nxt = merge16(key_r, wdata_r, wstrb_r);
            end
            ADDR_COMMIT: begin
               wv = merge16(KEY_CLEAR, wdata_r, wstrb_r);
               if (wv == COMMIT_SAVE) begin
                  store_nxt = 1'b1;
                  dirty_nxt = 1'b0;
               end
            end
            ADDR_STATUS: begin
               bresp_nxt = RESP_SLVERR;
            end
            default: begin
               bresp_nxt = RESP_DECERR;
            end
         endcase
      end
      // Macro then fieldbus writes skip the guard and win a tie; fieldbus is applied last and wins over macro
      if (macro_src_wr.valid && rpg_src_legal(macro_src_wr.value)) begin
         src_nxt = macro_src_wr.value;
      end
      if (fb_src_wr.valid && rpg_src_legal(fb_src_wr.value)) begin
         src_nxt = fb_src_wr.value;
      end
      awready_nxt = !aw_hold_nxt;
      wready_nxt = !w_hold_nxt;
      // Registered so the pin never shows a compare glitch
      blocked_nxt = (guard_nxt == GUARD_EDITS_BLOCKED);
   end

   // ****************************************************************
   // Read channel
   // ****************************************************************
   // One read in flight; a new address waits for rready
   always_comb begin
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
      if (s_axi_arvalid && arready_r) begin
         rvalid_nxt = 1'b1;
         rresp_nxt = RESP_OKAY;
         rdata_nxt = '0;
         unique case (s_axi_araddr & ADDR_WORD_MASK)
            ADDR_SRC: rdata_nxt[PARAM_W-1:0] = src_r;
            ADDR_GUARD: rdata_nxt[PARAM_W-1:0] = guard_r;
            ADDR_KEY: rdata_nxt[PARAM_W-1:0] = key_r;
            ADDR_COMMIT: rdata_nxt = '0;
            ADDR_STATUS: rdata_nxt[$bits(rpg_status_t)-1:0] = status;
            default: rresp_nxt = RESP_DECERR;
         endcase
      end
      arready_nxt = !rvalid_nxt;
   end

   // ****************************************************************
   // Run permit
   // ****************************************************************
   // Recomputed every cycle; a start is only granted on a live permit
   always_comb begin
      permit_nxt = permit_of(src_r, di_s, fb_cmd_word);
      coast_nxt = !permit_nxt;
      grant_nxt = start_req && permit_r;
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         awready_r <= 1'b0;
         wready_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= '0;
         wstrb_r <= '0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= RESP_OKAY;
         src_r <= SRC_RESET;
         guard_r <= GUARD_RESET;
         key_r <= KEY_CLEAR;
         dirty_r <= 1'b0;
         store_r <= 1'b0;
         persist_r <= 1'b0;
         permit_r <= 1'b0;
         coast_r <= 1'b1;
         grant_r <= 1'b0;
         blocked_r <= (GUARD_RESET == GUARD_EDITS_BLOCKED);
      end else begin
         aw_hold_r <= aw_hold_nxt;
         w_hold_r <= w_hold_nxt;
         awready_r <= awready_nxt;
         wready_r <= wready_nxt;
         awaddr_r <= awaddr_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         arready_r <= arready_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
         src_r <= src_nxt;
         guard_r <= guard_nxt;
         key_r <= key_nxt;
         dirty_r <= dirty_nxt;
         store_r <= store_nxt;
         persist_r <= persist_nxt;
         permit_r <= permit_nxt;
         coast_r <= coast_nxt;
         grant_r <= grant_nxt;
         blocked_r <= blocked_nxt;
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign run_permit = permit_r;
   assign coast_stop = coast_r;
   assign start_grant = grant_r;
   assign persist_pulse = persist_r;
   assign store_all = store_r;
   assign edits_blocked = blocked_r;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   logic no_bypass;
   assign no_bypass = !fb_src_wr.valid && !macro_src_wr.valid;

   sequence s_panel_src_wr;
      wr_do && awaddr_r == ADDR_SRC && no_bypass;
   endsequence

   sequence s_commit_wr;
      wr_do && awaddr_r == ADDR_COMMIT && wstrb_r == 2'h3 &&
         wdata_r == COMMIT_SAVE;
   endsequence

   a_none_permits: assert property (
      (aresetn && src_r == SRC_NONE) |=> permit_r && !coast_r)
      else $error("source none did not permit");
   a_di1_permit: assert property (
      (src_r == SRC_DI_FIRST) |=> (permit_r == $past(di_s[0])))
      else $error("permit does not follow input one");
   a_loss_refuses_start: assert property (
      (start_req && !permit_r) |=> !start_grant)
      else $error("start granted without permit");
   a_di6_permit: assert property (
      (src_r == SRC_DI_LAST) |=> (permit_r == $past(di_s[5])))
      else $error("permit does not follow input six");
   a_fieldbus_disable: assert property (
      (src_r == SRC_FIELDBUS) |=>
         (permit_r == !$past(fb_cmd_word[FB_DISABLE_BIT])))
      else $error("fieldbus disable bit ignored");
   a_inv_permit: assert property (
      (src_r == SRC_INV_FIRST) |=> (permit_r == !$past(di_s[0])))
      else $error("inverted input one wrong");
   a_inv_coast: assert property (
      (src_r == SRC_INV_LAST && di_s[5]) |=> coast_r ##1 !start_grant)
      else $error("inverted source did not coast");
   a_edits_blocked_reject: assert property (
      (s_panel_src_wr and guard_r == GUARD_EDITS_BLOCKED) |=>
         $stable(src_r) && bvalid_r && bresp_r == RESP_SLVERR)
      else $error("edits_blocked guard let a panel edit through");
   a_bypass_write: assert property (
      (fb_src_wr.valid && rpg_src_legal(fb_src_wr.value)) |=>
         (src_r == $past(fb_src_wr.value)))
      else $error("fieldbus write was blocked");
   a_guard_needs_key: assert property (
      (wr_do && awaddr_r == ADDR_GUARD && key_r != UNLOCK_KEY) |=>
         $stable(guard_r) && bresp_r == RESP_SLVERR)
      else $error("guard changed without unlock code");
   a_open_persist: assert property (
      (s_panel_src_wr and guard_r == GUARD_OPEN &&
         wstrb_r == 2'h3 && rpg_src_legal(wdata_r)) |=>
         persist_pulse && $stable(dirty_r))
      else $error("open guard did not persist change");
   a_unsaved_dirty: assert property (
      (s_panel_src_wr and guard_r == GUARD_UNSAVED &&
         wstrb_r == 2'h3 && rpg_src_legal(wdata_r)) |=>
         dirty_r && !persist_pulse)
      else $error("unsaved guard wrote permanent memory");
   a_commit_stores: assert property (
      s_commit_wr |=> store_all && !dirty_r ##1 !store_all)
      else $error("save request did not store");
   a_key_one_shot: assert property (
      (wr_do && awaddr_r == ADDR_GUARD && key_r == UNLOCK_KEY &&
         wstrb_r == 2'h3 && wdata_r <= GUARD_UNSAVED) |=>
         key_r == KEY_CLEAR && guard_r == $past(wdata_r))
      else $error("unlock code not consumed");
   a_reset_no_permit: assert property (
      @(posedge aclk) disable iff (1'b0)
      !aresetn |=> !run_permit && coast_stop)
      else $error("permit high after reset");

endmodule

// [src/rpg_pkg.sv]
package rpg_pkg;

   // ****************************************************************
   // Bus geometry
   // ****************************************************************
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;
   localparam int PARAM_W = 16;
   localparam int NUM_DI_DEF = 6;
   localparam int SYNC_STAGES = 2;

   // ****************************************************************
   // Register map, byte addresses
   // ****************************************************************
   localparam logic [ADDR_W-1:0] ADDR_SRC = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_GUARD = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_KEY = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_COMMIT = 8'h0c;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h10;
   localparam logic [ADDR_W-1:0] ADDR_WORD_MASK = 8'hfc;

   // ****************************************************************
   // Run-permit source codes
   // ****************************************************************
   localparam logic signed [PARAM_W-1:0] SRC_NONE = 16'sh0000;
   localparam logic signed [PARAM_W-1:0] SRC_DI_FIRST = 16'sh0001;
   localparam logic signed [PARAM_W-1:0] SRC_DI_LAST = 16'sh0006;
   localparam logic signed [PARAM_W-1:0] SRC_FIELDBUS = 16'sh0007;
   localparam logic signed [PARAM_W-1:0] SRC_INV_FIRST = 16'shffff;
   localparam logic signed [PARAM_W-1:0] SRC_INV_LAST = 16'shfffa;
   localparam logic signed [PARAM_W-1:0] SRC_RESET = SRC_NONE;
   localparam int FB_DISABLE_BIT = 6;

   // ****************************************************************
   // Edit guard, unlock and save values
   // ****************************************************************
   localparam logic [PARAM_W-1:0] GUARD_EDITS_BLOCKED = 16'h0000;
   localparam logic [PARAM_W-1:0] GUARD_OPEN = 16'h0001;
   localparam logic [PARAM_W-1:0] GUARD_UNSAVED = 16'h0002;
   localparam logic [PARAM_W-1:0] GUARD_RESET = GUARD_OPEN;
   localparam logic [PARAM_W-1:0] UNLOCK_KEY = 16'h0166;
   localparam logic [PARAM_W-1:0] KEY_CLEAR = 16'h0000;
   localparam logic [PARAM_W-1:0] COMMIT_SAVE = 16'h0001;

   // ****************************************************************
   // Status word and responses
   // ****************************************************************
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // Source write from a party that bypasses the edit guard
   typedef struct packed {
      logic valid;
      logic signed [PARAM_W-1:0] value;
   } rpg_src_wr_t;

   // Status word, bit 0 is permit
   typedef struct packed {
      logic blocked;
      logic unlocked;
      logic dirty;
      logic coast;
      logic permit;
   } rpg_status_t;

   // Legal run-permit source code
   function automatic logic rpg_src_legal(
      input logic signed [PARAM_W-1:0] s);
      return (s >= SRC_INV_LAST) && (s <= SRC_FIELDBUS);
   endfunction

endpackage

// [src/rpg_sync.sv]
`timescale 1ns/1ps
// Two-stage level synchroniser for pin inputs
module rpg_sync
   import rpg_pkg::*;
#(
   parameter int WIDTH = NUM_DI_DEF
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_sync
);

   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] sync_r;

   // First stage only feeds the second; inputs read low in reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= pin_in;
         sync_r <= meta_r;
      end
   end

   assign pin_sync = sync_r;

endmodule

// [dv/rpg_far_model.sv]
`timescale 1ns/1ps
// ********************
// Far side: input pins and fieldbus master
// ********************
module rpg_far_model (
   input wire logic aclk,
   input wire logic [5:0] di_set,
   input wire logic [15:0] word_set,
   output logic [5:0] di_pin,
   output logic [15:0] fb_cmd_word
);
   // Pins and command word move only after an edge; unknown until the
   // first edge, which falls inside reset
   always @(posedge aclk) begin
      di_pin <= di_set;
      fb_cmd_word <= word_set;
   end
endmodule

// [dv/testbench.sv]
`timescale 1ns/1ps
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin n_errors++; \
 $display("wrong value %s expected %h seen %h", nm, e, s); end end
module testbench;
   import rpg_pkg::*;
   typedef struct packed {
      logic [15:0] src;
      logic [5:0] di;
      logic [15:0] fw;
      logic ok;
   } rpg_row_t;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, start_req, run_permit;
   logic coast_stop, start_grant, persist_pulse, store_all, edits_blocked;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [DATA_W-1:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic [5:0] di_set, di_pin;
   logic [15:0] word_set, fb_word;
   rpg_src_wr_t fb_wr, mc_wr;
   int n_errors = 0;
   int checks = 0;
   int n_persist = 0;
   int n_store = 0;
   int p0, i;
   // Source, pins, command word, expected permit
   rpg_row_t rows [19] = '{
      {16'h0,6'h0,16'h0,1'b1}, {16'h1,6'h1,16'h0,1'b1},
      {16'h1,6'h3e,16'h0,1'b0}, {16'h2,6'h2,16'h0,1'b1},
      {16'h2,6'h3d,16'h0,1'b0}, {16'h3,6'h4,16'h0,1'b1},
      {16'h4,6'h8,16'h0,1'b1}, {16'h5,6'h10,16'h0,1'b1},
      {16'h6,6'h20,16'h0,1'b1}, {16'h6,6'h1f,16'h0,1'b0},
      {16'h7,6'h0,16'h0,1'b1}, {16'h7,6'h0,16'h40,1'b0},
      {16'h7,6'h3f,16'hffbf,1'b1}, {16'hffff,6'h0,16'h0,1'b1},
      {16'hffff,6'h1,16'h0,1'b0}, {16'hfffe,6'h3d,16'h0,1'b1},
      {16'hfffa,6'h20,16'h0,1'b0}, {16'hfffa,6'h1f,16'h0,1'b1},
      {16'h0,6'h3f,16'hffff,1'b1}};

   // ********************
   // Clock, parts and pulse counting
   // ********************
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   rpg_far_model far_u (.aclk(aclk), .di_set(di_set), .word_set(word_set),
      .di_pin(di_pin), .fb_cmd_word(fb_word));
   rpg_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .di_pin(di_pin), .fb_cmd_word(fb_word),
      .fb_src_wr(fb_wr), .macro_src_wr(mc_wr), .start_req(start_req),
      .run_permit(run_permit), .coast_stop(coast_stop),
      .start_grant(start_grant), .persist_pulse(persist_pulse),
      .store_all(store_all), .edits_blocked(edits_blocked));
   // Mid-cycle sampling sees each one-cycle pulse exactly once
   always @(negedge aclk) begin
      if (persist_pulse === 1'b1) n_persist++;
      if (store_all === 1'b1) n_store++;
   end

   // ********************
   // Bus tasks and verdict
   // ********************
   task automatic give_verdict();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Readies sampled mid-cycle, so the release after an edge is race free
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
         input logic [1:0] er);
      int k;
      logic ra, rw, done;
      done = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (k = 0; k < 50 && !done; k++) begin
         @(negedge aclk);
         ra = awready;
         rw = wready;
         done = (bvalid === 1'b1);
         if (done) `CHK("bresp", er, bresp)
         @(posedge aclk);
         if (ra === 1'b1) awvalid <= 1'b0;
         if (rw === 1'b1) wvalid <= 1'b0;
         if (done) bready <= 1'b0;
      end
      if (!done) begin
         n_errors++;
         give_verdict();
      end
   endtask
   // Read data is only meaningful on an OKAY answer
   task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
         input logic [1:0] er);
      int k;
      logic ra, done;
      done = 1'b0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (k = 0; k < 50 && !done; k++) begin
         @(negedge aclk);
         ra = arready;
         done = (rvalid === 1'b1);
         if (done) begin
            `CHK("rresp", er, rresp)
            if (er == RESP_OKAY) `CHK("rdata", ed, rdata)
         end
         @(posedge aclk);
         if (ra === 1'b1) arvalid <= 1'b0;
         if (done) rready <= 1'b0;
      end
      if (!done) begin
         n_errors++;
         give_verdict();
      end
   endtask

   // ********************
   // Main sequence
   // ********************
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      {awaddr, araddr, wdata, di_set, word_set} = '0;
      wstrb = 4'hf;
      fb_wr = '0;
      mc_wr = '0;
      start_req = 1'b0;
      @(posedge aclk);
      @(negedge aclk);
      `CHK("reset permit", 1'b0, run_permit)
      `CHK("reset coast", 1'b1, coast_stop)
      @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      axi_rd(ADDR_SRC, 32'h0, RESP_OKAY);
      axi_rd(ADDR_GUARD, 32'h1, RESP_OKAY);
      axi_rd(ADDR_KEY, 32'h0, RESP_OKAY);
      axi_rd(ADDR_STATUS, 32'h1, RESP_OKAY);
      start_req <= 1'b1;
      for (i = 0; i < 19; i++) begin
         @(posedge aclk);
         di_set <= rows[i].di;
         word_set <= rows[i].fw;
         axi_wr(ADDR_SRC, {16'h0, rows[i].src}, RESP_OKAY);
         repeat (6) @(posedge aclk);
         @(negedge aclk);
         `CHK("run_permit", rows[i].ok, run_permit)
         `CHK("coast_stop", ~rows[i].ok, coast_stop)
         `CHK("start_grant", rows[i].ok, start_grant)
      end
      // Refusals, then the unlock and the one-shot guard change
      axi_wr(8'h20, 32'h0, RESP_DECERR);
      axi_rd(8'h20, 32'h0, RESP_DECERR);
      axi_wr(ADDR_STATUS, 32'h0, RESP_SLVERR);
      axi_wr(ADDR_SRC, 32'h8, RESP_SLVERR);
      axi_wr(ADDR_GUARD, 32'h0, RESP_SLVERR);
      axi_wr(ADDR_KEY, 32'h166, RESP_OKAY);
      axi_rd(ADDR_STATUS, 32'h9, RESP_OKAY);
      axi_wr(ADDR_GUARD, 32'h0, RESP_OKAY);
      axi_rd(ADDR_KEY, 32'h0, RESP_OKAY);
      `CHK("edits_blocked", 1'b1, edits_blocked)
      axi_wr(ADDR_SRC, 32'h1, RESP_SLVERR);
      axi_rd(ADDR_SRC, 32'h0, RESP_OKAY);
      axi_wr(ADDR_GUARD, 32'h1, RESP_SLVERR);
      // Fieldbus and macro writes go round the lock
      @(posedge aclk);
      fb_wr <= {1'b1, 16'h0007};
      @(posedge aclk);
      fb_wr <= '0;
      axi_rd(ADDR_SRC, 32'h7, RESP_OKAY);
      mc_wr <= {1'b1, 16'hfffe};
      @(posedge aclk);
      mc_wr <= '0;
      axi_rd(ADDR_SRC, 32'hfffe, RESP_OKAY);
      // Unsaved mode, then commit, then open mode again
      axi_wr(ADDR_KEY, 32'h166, RESP_OKAY);
      axi_wr(ADDR_GUARD, 32'h2, RESP_OKAY);
      `CHK("edits_blocked", 1'b0, edits_blocked)
      p0 = n_persist;
      axi_wr(ADDR_SRC, 32'h0, RESP_OKAY);
      `CHK("persist count", 0, n_persist - p0)
      axi_rd(ADDR_STATUS, 32'h5, RESP_OKAY);
      p0 = n_store;
      axi_wr(ADDR_COMMIT, 32'h1, RESP_OKAY);
      `CHK("store count", 1, n_store - p0)
      axi_rd(ADDR_STATUS, 32'h1, RESP_OKAY);
      axi_wr(ADDR_KEY, 32'h166, RESP_OKAY);
      axi_wr(ADDR_GUARD, 32'h1, RESP_OKAY);
      p0 = n_persist;
      axi_wr(ADDR_SRC, 32'h2, RESP_OKAY);
      `CHK("persist count", 1, n_persist - p0)
      // Second reset mid-run: permit drops, source returns to none
      aresetn <= 1'b0;
      @(posedge aclk);
      @(negedge aclk);
      `CHK("mid reset permit", 1'b0, run_permit)
      `CHK("mid reset coast", 1'b1, coast_stop)
      @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      axi_rd(ADDR_SRC, 32'h0, RESP_OKAY);
      axi_rd(ADDR_STATUS, 32'h1, RESP_OKAY);
      give_verdict();
   end
endmodule
